// File: design/wct_map.svh
`ifndef WCT_MAP_SVH
`define WCT_MAP_SVH

// ************************************************************
// register word addresses
// ************************************************************
`define WCT_ADDR_MANUAL      16'h8000
`define WCT_ADDR_DI_A        16'h8001
`define WCT_ADDR_DI_B        16'h8002
`define WCT_ADDR_DI_C        16'h8003
`define WCT_ADDR_V_NOM       16'h8004
`define WCT_ADDR_SAG_EN      16'h8005
`define WCT_ADDR_SAG_PCT     16'h8006
`define WCT_ADDR_SAG_HC      16'h8007
`define WCT_ADDR_SWELL_EN    16'h8008
`define WCT_ADDR_SWELL_PCT   16'h8009
`define WCT_ADDR_SPARE       16'h800A
`define WCT_ADDR_I_NOM       16'h800B
`define WCT_ADDR_OC_EN       16'h800C
`define WCT_ADDR_OC_PCT      16'h800D
`define WCT_ADDR_ERASE_WAVE  16'h800E
`define WCT_ADDR_ERASE_PQ    16'h800F
`define WCT_ADDR_SELECT      16'h8E00
`define WCT_ADDR_WIN_GROUP   16'h8E01
`define WCT_ADDR_STATUS      16'h8E02
`define WCT_ADDR_NEWEST      16'h8E03
`define WCT_ADDR_WIN_FIRST   16'h8E04
`define WCT_ADDR_WIN_LAST    16'h8E43

// ************************************************************
// reset values
// ************************************************************
`define WCT_RST_V_NOM        16'h0190
`define WCT_RST_SAG_PCT      16'h0032
`define WCT_RST_SAG_HC       16'h000A
`define WCT_RST_SWELL_PCT    16'h0064
`define WCT_RST_I_NOM        16'h1388
`define WCT_RST_OC_PCT       16'h0064

// ************************************************************
// command and status codes
// ************************************************************
`define WCT_CMD_MANUAL       16'h00AA
`define WCT_CMD_ERASE        16'h0055
`define WCT_STAT_VALID       16'h000B
`define WCT_STAT_INVALID     16'h00FF
`define WCT_STAT_CLEARING    16'h00AA
`define WCT_GROUP_MAX        16'h0064
`define WCT_DI_COUNT         14

// ************************************************************
// sample scaling gains, q16, raw in 10 mV or 0.1 mA units
// ************************************************************
`define WCT_GAIN_VOLT        18'h0_603C
`define WCT_GAIN_AMP         18'h0_2B17
`define WCT_GAIN_AMP_333     18'h1_9645
`define WCT_SAT_POS          16'h7FFF
`define WCT_SAT_NEG          16'h8000

`endif

// File: design/wct_pkg.sv
package wct_pkg;
    typedef enum logic [1:0] {
        WCT_IDLE,
        WCT_LOADING,
        WCT_CLEARING
    } wct_state_type;

    typedef enum logic [2:0] {
        WCT_CAUSE_NONE,
        WCT_CAUSE_MANUAL,
        WCT_CAUSE_DIGITAL,
        WCT_CAUSE_SAG,
        WCT_CAUSE_SWELL,
        WCT_CAUSE_OVERCURRENT
    } wct_cause_type;

    typedef enum logic [2:0] {
        WCT_THREE_PHASE_FOUR_WIRE,
        WCT_THREE_PHASE_THREE_WIRE_LINE,
        WCT_TWO_ELEMENT_LINE,
        WCT_SINGLE_PHASE_NEUTRAL,
        WCT_SINGLE_PHASE_LINE
    } wct_wiring_type;
endpackage

// File: design/wct_sample_scale.sv
`timescale 1ns/10ps
`include "wct_map.svh"

module wct_sample_scale
    import wct_pkg::*;
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    // raw sample in
    input  wire logic        in_valid_i,
    input  wire logic [5:0]  in_index_i,
    input  wire logic        in_current_i,
    input  wire logic        in_last_i,
    input  wire logic [15:0] in_sample_i,
    input  wire logic        ct_333mv_i,
    // scaled sample out
    output logic             out_valid_o,
    output logic [5:0]       out_index_o,
    output logic             out_last_o,
    output logic [15:0]      out_sample_o
);
    logic        valid_q, valid_d;
    logic [5:0]  index_q, index_d;
    logic        last_q, last_d;
    logic [15:0] sample_q, sample_d;
    logic [17:0] gain;
    logic signed [34:0] product;
    logic signed [18:0] shifted;

    // gain pick, values are secondary-side quantities, no ratio applied
    // R9: secondary side, no ratio
    always_comb begin
        // R6: voltage gain
        gain = `WCT_GAIN_VOLT;
        if (in_current_i) begin
            // R7: ordinary current gain
            // R8: 333 mV sensor gain
            gain = ct_333mv_i ? `WCT_GAIN_AMP_333 : `WCT_GAIN_AMP;
        end
        product = $signed(in_sample_i) * $signed({1'b0, gain});
        shifted = product[34:16];
        valid_d = in_valid_i;
        index_d = in_index_i;
        last_d  = in_valid_i & in_last_i;
        // R5: clamp to signed word range
        if (shifted > 19'sd32767) begin
            sample_d = `WCT_SAT_POS;
        end else if (shifted < -19'sd32768) begin
            sample_d = `WCT_SAT_NEG;
        end else begin
            sample_d = shifted[15:0];
        end
    end

    // one pipeline stage
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            valid_q  <= 1'b0;
            index_q  <= 6'h00;
            last_q   <= 1'b0;
            sample_q <= 16'h0000;
        end else begin
            valid_q  <= valid_d;
            index_q  <= index_d;
            last_q   <= last_d;
            sample_q <= sample_d;
        end
    end

    assign out_valid_o  = valid_q;
    assign out_index_o  = index_q;
    assign out_last_o   = last_q;
    assign out_sample_o = sample_q;

    scale_voltage_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R6
        in_valid_i && !in_current_i && in_sample_i == 16'h0400
        |=> out_valid_o && out_sample_o == 16'h0180)
        else $error("voltage scaling wrong");
    scale_333_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R8
        in_valid_i && in_current_i && ct_333mv_i && in_sample_i == 16'h0400
        |=> out_sample_o == 16'h0659)
        else $error("333 mV current scaling wrong");
endmodule // wct_sample_scale

// File: design/wct_regs.sv
// Overview of operation
// R1: write group number, then read its waveform
// R2: one waveform group exposed at a time
// R3: group valid only up to newest group
// R4: status reads 0x0B valid, 0xFF, 0xAA clearing
// R5: 64 signed sample words, read only
// R6: voltage sample over 37.59105 gives volts
// R7: current sample over 1683.153 gives amperes
// R8: 333 mV sensor: divide by 15869.87
// R9: recovered values are transformer secondary side
// R10: rated voltage line type in line wirings; code flags three-wire and two-element line only, not single-phase line
// R11: two-bit digital input trigger codes per input
// R12: trigger stores record, advances newest number
`timescale 1ns/10ps
`include "wct_map.svh"

module wct_regs
    import wct_pkg::*;
(
    // clock and reset
    input  wire logic           clock_i,
    input  wire logic           rstn_i,
    // register access, read and preset words
    input  wire logic           acc_valid_i,
    input  wire logic           acc_write_i,
    input  wire logic [15:0]    acc_addr_i,
    input  wire logic [15:0]    acc_wdata_i,
    output logic                resp_valid_o,
    output logic                resp_err_o,
    output logic [15:0]         resp_rdata_o,
    // trigger sources, wiring mode and 333 mV sensor select
    input  wire logic [13:0]    digital_input_i,
    input  wire logic           sag_event_i,
    input  wire logic           swell_event_i,
    input  wire logic           overcurrent_event_i,
    input  wire wct_wiring_type wiring_mode_i,
    input  wire logic           ct_333mv_i,
    // record store
    output logic                capture_req_o,
    output wct_cause_type       capture_cause_o,
    output logic [15:0]         capture_group_o,
    output logic                erase_req_o,
    input  wire logic           erase_done_i,
    output logic                pq_clear_o,
    output logic                fetch_req_o,
    output logic [15:0]         fetch_group_o,
    input  wire logic           fetch_valid_i,
    input  wire logic [5:0]     fetch_index_i,
    input  wire logic           fetch_current_i,
    input  wire logic           fetch_last_i,
    input  wire logic [15:0]    fetch_sample_i,
    // settings toward the measurement front end
    output logic                nominal_line_o,
    output logic [15:0]         voltage_nominal_o,
    output logic [15:0]         sag_threshold_o,
    output logic [15:0]         sag_cycles_o,
    output logic [15:0]         swell_threshold_o,
    output logic [15:0]         current_nominal_o,
    output logic [15:0]         overcurrent_threshold_o
);
    // ************************************************************
    // state
    // ************************************************************
    logic [15:0]   cfg_q [16];
    logic [15:0]   cfg_d [16];
    logic [15:0]   select_q, select_d, wgroup_q, wgroup_d;
    logic [15:0]   status_q, status_d, newest_q, newest_d;
    logic [15:0]   rdata_q, rdata_d;
    logic [15:0]   cap_grp_q, cap_grp_d, fgrp_q, fgrp_d;
    logic [13:0]   di_q;
    logic          rvalid_q, rerr_q, rerr_d;
    logic          cap_q, cap_d, erase_q, erase_d, pq_q, pq_d, freq_q, freq_d;
    logic          line_q, line_d;
    wct_cause_type cause_q, cause_d;
    wct_state_type state_q, state_d;
    logic [15:0]   win_q [64];
    logic [15:0]   win_d [64];
    logic [13:0]   di_hit;
    logic          sc_valid, sc_last;
    logic [5:0]    sc_index;
    logic [15:0]   sc_sample;
    logic          wr, map_ok, ro_hit, sel_ok;
    logic [3:0]    cfg_idx;

    // decodes used by both read and write paths
    function automatic logic is_cfg(input logic [15:0] a);
        return a[15:4] == `WCT_ADDR_MANUAL >> 4;
    endfunction
    function automatic logic is_win(input logic [15:0] a);
        return a >= `WCT_ADDR_WIN_FIRST && a <= `WCT_ADDR_WIN_LAST;
    endfunction
    function automatic logic di_fire(input logic [1:0] code, input logic was, input logic now);
        return (code[0] & ~was & now) | (code[1] & was & ~now);
    endfunction

    // ************************************************************
    // digital input triggers
    // ************************************************************
    // R11: per-input two-bit edge codes
    for (genvar gi = 0; gi < `WCT_DI_COUNT; gi++) begin : g_di
        if (gi < 6) begin : g_a
            assign di_hit[gi] = di_fire(cfg_q[1][2*gi +: 2], di_q[gi], digital_input_i[gi]);
        end else if (gi < 10) begin : g_b
            assign di_hit[gi] = di_fire(cfg_q[2][2*(gi-6) +: 2], di_q[gi],
                                        digital_input_i[gi]);
        end else begin : g_c
            assign di_hit[gi] = di_fire(cfg_q[3][2*(gi-10) +: 2], di_q[gi],
                                        digital_input_i[gi]);
        end
    end

    // R5: scaled samples into the window
    wct_sample_scale u_scale (
        .clock_i      (clock_i),
        .rstn_i       (rstn_i),
        .in_valid_i   (fetch_valid_i && state_q == WCT_LOADING),
        .in_index_i   (fetch_index_i),
        .in_current_i (fetch_current_i),
        .in_last_i    (fetch_last_i),
        .in_sample_i  (fetch_sample_i),
        .ct_333mv_i   (ct_333mv_i),
        .out_valid_o  (sc_valid),
        .out_index_o  (sc_index),
        .out_last_o   (sc_last),
        .out_sample_o (sc_sample)
    );

    // ************************************************************
    // next state of registers, triggers and retrieval
    // ************************************************************
    always_comb begin
        cfg_d    = cfg_q;
        win_d    = win_q;
        select_d = select_q;
        wgroup_d = wgroup_q;
        status_d = status_q;
        newest_d = newest_q;
        cap_grp_d = cap_grp_q;
        fgrp_d   = fgrp_q;
        state_d  = state_q;
        cap_d    = 1'b0;
        cause_d  = WCT_CAUSE_NONE;
        erase_d  = 1'b0;
        pq_d     = 1'b0;
        freq_d   = 1'b0;
        cfg_idx  = acc_addr_i[3:0];
        wr       = acc_valid_i && acc_write_i;
        // R3: select only within recorded groups
        sel_ok   = acc_wdata_i != 16'h0000 && acc_wdata_i <= newest_q
                   && acc_wdata_i <= `WCT_GROUP_MAX;
        ro_hit   = acc_addr_i == `WCT_ADDR_STATUS || acc_addr_i == `WCT_ADDR_NEWEST
                   || is_win(acc_addr_i);
        map_ok   = is_cfg(acc_addr_i) || acc_addr_i == `WCT_ADDR_SELECT
                   || acc_addr_i == `WCT_ADDR_WIN_GROUP || ro_hit;
        rerr_d   = acc_valid_i && (!map_ok || (acc_write_i && ro_hit));
        // R10: rated voltage is line voltage in three-wire and two-element line wirings, not in single-phase line
        line_d   = wiring_mode_i == WCT_THREE_PHASE_THREE_WIRE_LINE
                   || wiring_mode_i == WCT_TWO_ELEMENT_LINE;
        // read path, reserved word reads zero
        rdata_d  = 16'h0000;
        if (acc_valid_i && !acc_write_i) begin
            if (is_cfg(acc_addr_i) && acc_addr_i != `WCT_ADDR_SPARE) begin
                rdata_d = cfg_q[cfg_idx];
            end else if (acc_addr_i == `WCT_ADDR_SELECT) begin
                rdata_d = select_q;
            end else if (acc_addr_i == `WCT_ADDR_WIN_GROUP) begin
                rdata_d = wgroup_q;
            end else if (acc_addr_i == `WCT_ADDR_STATUS) begin
                rdata_d = status_q;
            end else if (acc_addr_i == `WCT_ADDR_NEWEST) begin
                rdata_d = newest_q;
            end else if (is_win(acc_addr_i)) begin
                rdata_d = win_q[6'(acc_addr_i - `WCT_ADDR_WIN_FIRST)];
            end
        end
        // configuration writes, spare word ignored
        if (wr && is_cfg(acc_addr_i) && acc_addr_i != `WCT_ADDR_SPARE) begin
            cfg_d[cfg_idx] = acc_wdata_i;
        end
        if (wr && acc_addr_i == `WCT_ADDR_WIN_GROUP) begin
            wgroup_d = acc_wdata_i;
        end
        // window fill from the scaler
        if (sc_valid && state_q == WCT_LOADING) begin
            win_d[sc_index] = sc_sample;
        end
        case (state_q)
            WCT_IDLE: begin
                // R12: trigger priority, manual first
                if (wr && acc_addr_i == `WCT_ADDR_MANUAL && acc_wdata_i == `WCT_CMD_MANUAL) begin
                    cause_d = WCT_CAUSE_MANUAL;
                end else if (|di_hit) begin
                    cause_d = WCT_CAUSE_DIGITAL;
                end else if (sag_event_i && cfg_q[5][0]) begin
                    cause_d = WCT_CAUSE_SAG;
                end else if (swell_event_i && cfg_q[8][0]) begin
                    cause_d = WCT_CAUSE_SWELL;
                end else if (overcurrent_event_i && cfg_q[12][0]) begin
                    cause_d = WCT_CAUSE_OVERCURRENT;
                end
                if (cause_d != WCT_CAUSE_NONE) begin
                    cap_d     = 1'b1;
                    newest_d  = newest_q == `WCT_GROUP_MAX ? 16'h0001 : newest_q + 16'h0001;
                    cap_grp_d = newest_d;
                end
                // R1: selector write of an in-range group starts a window load
                if (wr && acc_addr_i == `WCT_ADDR_SELECT) begin
                    select_d = acc_wdata_i;
                    // R4: invalid until the load completes
                    status_d = `WCT_STAT_INVALID;
                    if (sel_ok) begin
                        freq_d  = 1'b1;
                        fgrp_d  = acc_wdata_i;
                        state_d = WCT_LOADING;
                    end
                end
                // R4: erase marks window as clearing
                if (wr && acc_addr_i == `WCT_ADDR_ERASE_WAVE && acc_wdata_i == `WCT_CMD_ERASE) begin
                    erase_d  = 1'b1;
                    cap_d    = 1'b0;
                    freq_d   = 1'b0;
                    newest_d = 16'h0000;
                    status_d = `WCT_STAT_CLEARING;
                    state_d  = WCT_CLEARING;
                end
            end
            WCT_LOADING: begin
                // R2: one group in the window at a time
                if (sc_valid && sc_last) begin
                    status_d = `WCT_STAT_VALID;
                    wgroup_d = fgrp_q;
                    state_d  = WCT_IDLE;
                end
            end
            WCT_CLEARING: begin
                if (erase_done_i) begin
                    status_d = `WCT_STAT_INVALID;
                    cfg_d[14] = 16'h0000;
                    state_d  = WCT_IDLE;
                end
            end
            default: begin
                state_d = WCT_IDLE;
            end
        endcase
        // quality event clear is a one-shot request
        if (wr && acc_addr_i == `WCT_ADDR_ERASE_PQ && acc_wdata_i == `WCT_CMD_ERASE) begin
            pq_d = 1'b1;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < 16; i++) begin
                cfg_q[i] <= 16'h0000;
            end
            cfg_q[4]  <= `WCT_RST_V_NOM;
            cfg_q[6]  <= `WCT_RST_SAG_PCT;
            cfg_q[7]  <= `WCT_RST_SAG_HC;
            cfg_q[9]  <= `WCT_RST_SWELL_PCT;
            cfg_q[11] <= `WCT_RST_I_NOM;
            cfg_q[13] <= `WCT_RST_OC_PCT;
            for (int i = 0; i < 64; i++) begin
                win_q[i] <= 16'h0000;
            end
            select_q  <= 16'h0000;
            wgroup_q  <= 16'h0000;
            status_q  <= `WCT_STAT_INVALID;
            newest_q  <= 16'h0000;
            rdata_q   <= 16'h0000;
            cap_grp_q <= 16'h0000;
            fgrp_q    <= 16'h0000;
            di_q      <= 14'h0000;
            rvalid_q  <= 1'b0;
            rerr_q    <= 1'b0;
            cap_q     <= 1'b0;
            erase_q   <= 1'b0;
            pq_q      <= 1'b0;
            freq_q    <= 1'b0;
            line_q    <= 1'b0;
            cause_q   <= WCT_CAUSE_NONE;
            state_q   <= WCT_IDLE;
        end else begin
            cfg_q     <= cfg_d;
            win_q     <= win_d;
            select_q  <= select_d;
            wgroup_q  <= wgroup_d;
            status_q  <= status_d;
            newest_q  <= newest_d;
            rdata_q   <= rdata_d;
            cap_grp_q <= cap_grp_d;
            fgrp_q    <= fgrp_d;
            di_q      <= digital_input_i;
            rvalid_q  <= acc_valid_i;
            rerr_q    <= rerr_d;
            cap_q     <= cap_d;
            erase_q   <= erase_d;
            pq_q      <= pq_d;
            freq_q    <= freq_d;
            line_q    <= line_d;
            cause_q   <= cause_d;
            state_q   <= state_d;
        end
    end

    // outputs straight from flops
    assign resp_valid_o            = rvalid_q;
    assign resp_err_o              = rerr_q;
    assign resp_rdata_o            = rdata_q;
    assign capture_req_o           = cap_q;
    assign capture_cause_o         = cause_q;
    assign capture_group_o         = cap_grp_q;
    assign erase_req_o             = erase_q;
    assign pq_clear_o              = pq_q;
    assign fetch_req_o             = freq_q;
    assign fetch_group_o           = fgrp_q;
    assign nominal_line_o          = line_q;
    assign voltage_nominal_o       = cfg_q[4];
    assign sag_threshold_o         = cfg_q[6];
    assign sag_cycles_o            = cfg_q[7];
    assign swell_threshold_o       = cfg_q[9];
    assign current_nominal_o       = cfg_q[11];
    assign overcurrent_threshold_o = cfg_q[13];

    // ************************************************************
    // checks
    // ************************************************************
    fetch_on_select_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R1
        state_q == WCT_IDLE && acc_valid_i && acc_write_i && acc_addr_i == `WCT_ADDR_SELECT
        && acc_wdata_i != 16'h0000 && acc_wdata_i <= newest_q
        && !(wr && acc_addr_i == `WCT_ADDR_ERASE_WAVE)
        |=> fetch_req_o && fetch_group_o == $past(acc_wdata_i))
        else $error("valid select did not start a fetch");
    select_reject_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R3
        state_q == WCT_IDLE && acc_valid_i && acc_write_i && acc_addr_i == `WCT_ADDR_SELECT
        && acc_wdata_i > newest_q
        |=> !fetch_req_o && status_q == `WCT_STAT_INVALID)
        else $error("out of range select accepted");
    erase_status_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R4
        state_q == WCT_IDLE && wr && acc_addr_i == `WCT_ADDR_ERASE_WAVE
        && acc_wdata_i == `WCT_CMD_ERASE
        |=> status_q == `WCT_STAT_CLEARING && newest_q == 16'h0000 && erase_req_o)
        else $error("erase did not show clearing");
    load_valid_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R4
        state_q == WCT_LOADING && sc_valid && sc_last
        |=> status_q == `WCT_STAT_VALID && wgroup_q == $past(fgrp_q))
        else $error("window not valid after last sample");
    window_write_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R5
        state_q == WCT_LOADING && sc_valid
        |=> win_q[$past(sc_index)] == $past(sc_sample))
        else $error("window sample not stored");
    di_rise_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R11
        state_q == WCT_IDLE && !acc_valid_i && cfg_q[1][1:0] == 2'b01
        && !di_q[0] && digital_input_i[0]
        |=> capture_req_o && capture_cause_o == WCT_CAUSE_DIGITAL)
        else $error("digital rise did not trigger");
    di_off_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R11
        (cfg_q[1] | cfg_q[2] | cfg_q[3]) == 16'h0000 && !acc_valid_i
        && !sag_event_i && !swell_event_i && !overcurrent_event_i
        |=> !capture_req_o)
        else $error("disabled trigger fired");
    newest_adv_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R12
        capture_req_o |-> newest_q != $past(newest_q) && capture_group_o == newest_q)
        else $error("newest group not advanced");
    nominal_line_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R10
        wiring_mode_i == WCT_TWO_ELEMENT_LINE ##1 wiring_mode_i == WCT_TWO_ELEMENT_LINE
        |-> nominal_line_o)
        else $error("line wiring not flagged");
endmodule // wct_regs

// File: tb/wct_store_model.sv
`timescale 1ns/10ps

module wct_store_model (
    // clock and reset
    input  wire logic   clock_i,
    input  wire logic   rstn_i,
    // requests from the block
    input  wire logic   fetch_req_i,
    input  wire logic   erase_req_i,
    // sample stream and erase answer
    output logic        fetch_valid_o,
    output logic [5:0]  fetch_index_o,
    output logic        fetch_current_o,
    output logic        fetch_last_o,
    output logic [15:0] fetch_sample_o,
    output logic        erase_done_o
);
    int cnt_q;
    int ers_q;
    // one group of 64 words; idle data shows the inverse
    assign fetch_valid_o   = cnt_q >= 0 && cnt_q < 64;
    assign fetch_index_o   = cnt_q[5:0];
    assign fetch_current_o = cnt_q[0];
    assign fetch_last_o    = cnt_q == 63;
    assign fetch_sample_o  = fetch_valid_o ? 16'h0400 : 16'hFBFF;
    assign erase_done_o    = ers_q == 1;
    // slow answers: stream starts two cycles late, erase takes six
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= 64;
            ers_q <= 0;
        end else begin
            cnt_q <= fetch_req_i ? -2 : (cnt_q < 64 ? cnt_q + 1 : cnt_q);
            ers_q <= erase_req_i ? 6 : (ers_q > 0 ? ers_q - 1 : 0);
        end
    end
endmodule // wct_store_model

// File: tb/tb.sv
`timescale 1ns/10ps

module tb;
    import wct_pkg::*;
    logic clock_i = 0, rstn_i = 0, acc_valid_i = 0, acc_write_i = 0, sag_event_i = 0;
    logic swell_event_i = 0, overcurrent_event_i = 0, ct_333mv_i = 0, er;
    logic resp_valid_o, resp_err_o, capture_req_o, erase_req_o, erase_done_i, pq_clear_o;
    logic fetch_req_o, fetch_valid_i, fetch_current_i, fetch_last_i, nominal_line_o;
    logic [15:0] acc_addr_i = 0, acc_wdata_i = 0, resp_rdata_o, capture_group_o, rd;
    logic [15:0] fetch_group_o, fetch_sample_i, voltage_nominal_o, sag_threshold_o;
    logic [15:0] sag_cycles_o, swell_threshold_o, current_nominal_o, overcurrent_threshold_o;
    logic [13:0] digital_input_i = 0;
    logic [5:0]  fetch_index_i;
    wct_cause_type  capture_cause_o;
    wct_wiring_type wiring_mode_i = WCT_THREE_PHASE_THREE_WIRE_LINE;
    int n_errors = 0, checks = 0;

    always #5 clock_i = ~clock_i;
    wct_regs i_wct_regs (.*);
    wct_store_model i_wct_store_model (.clock_i(clock_i), .rstn_i(rstn_i),
        .fetch_req_i(fetch_req_o), .erase_req_i(erase_req_o), .fetch_valid_o(fetch_valid_i),
        .fetch_index_o(fetch_index_i), .fetch_current_o(fetch_current_i),
        .fetch_last_o(fetch_last_i), .fetch_sample_o(fetch_sample_i),
        .erase_done_o(erase_done_i));

    // ************************************************************
    // access and compare tasks
    // ************************************************************
    task chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // answer is looked at in its single cycle, at the following falling edge
    task acc(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(negedge clock_i);
        {acc_valid_i, acc_write_i, acc_addr_i, acc_wdata_i} = {1'b1, w, a, d};
        @(negedge clock_i);
        rd = resp_valid_o === 1'b1 ? resp_rdata_o : 16'hxxxx;
        er = resp_err_o;
        acc_valid_i = 0;
    endtask
    task rdc(input logic [15:0] a, input logic [15:0] e);
        acc(0, a, 16'h0000);
        chk(rd, e);
    endtask
    task poll(input logic [15:0] e);
        for (int k = 0; k < 100 && rd !== e; k++) acc(0, 16'h8E02, 16'h0000);
    endtask
    task test_done;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ************************************************************
    // watchdog and main sequence
    // ************************************************************
    initial begin
        #100us;
        n_errors++;
        test_done;
    end
    initial begin
        repeat (4) @(posedge clock_i);
        @(negedge clock_i) rstn_i = 1;
        rdc(16'h8004, 16'h0190);
        rdc(16'h800B, 16'h1388);
        rdc(16'h8E02, 16'h00FF);
        rdc(16'h8E03, 16'h0000);
        chk({15'h0000, nominal_line_o}, 16'h0001);
        wiring_mode_i = WCT_TWO_ELEMENT_LINE;
        repeat (2) @(negedge clock_i);
        chk({15'h0000, nominal_line_o}, 16'h0001);
        wiring_mode_i = WCT_THREE_PHASE_FOUR_WIRE;
        @(negedge clock_i);
        chk({15'h0000, nominal_line_o}, 16'h0000);
        acc(1, 16'h8E02, 16'h0001);
        chk({15'h0000, er}, 16'h0001);
        acc(1, 16'h8E04, 16'h0001);
        chk({15'h0000, er}, 16'h0001);
        acc(1, 16'h8000, 16'h00AA);
        rdc(16'h8E03, 16'h0001);
        acc(1, 16'h8005, 16'h0001);
        @(negedge clock_i) sag_event_i = 1;
        @(negedge clock_i) sag_event_i = 0;
        rdc(16'h8E03, 16'h0002);
        acc(1, 16'h8001, 16'h0001);
        @(negedge clock_i) digital_input_i = 14'h0001;
        rdc(16'h8E03, 16'h0003);
        chk(capture_group_o, 16'h0003);
        acc(1, 16'h8E00, 16'h0003);
        poll(16'h000B);
        chk(rd, 16'h000B);
        chk(fetch_group_o, 16'h0003);
        rdc(16'h8E01, 16'h0003);
        rdc(16'h8E04, 16'h0180);
        rdc(16'h8E05, 16'h00AC);
        rdc(16'h8E43, 16'h00AC);
        ct_333mv_i = 1;
        acc(1, 16'h8E00, 16'h0003);
        poll(16'h000B);
        rdc(16'h8E05, 16'h0659);
        acc(1, 16'h8E00, 16'h0004);
        rdc(16'h8E02, 16'h00FF);
        acc(1, 16'h800E, 16'h0055);
        rdc(16'h8E02, 16'h00AA);
        rdc(16'h8E03, 16'h0000);
        poll(16'h00FF);
        chk(rd, 16'h00FF);
        test_done;
    end
endmodule // tb
